// File: logic/dtcs_top.sv
// Dual timer with shared clock select register and register port.
`timescale 1ns/1ps
`default_nettype none
module dtcs_top
    import dtcs_pkg::*;
(
    // Clock and reset
    input  wire logic          CLK,
    input  wire logic          RSTN,
    // Register port
    input  wire dtcs_sfr_req_t SFR_REQ,
    output logic [7:0]         SFR_RDATA,
    // External pins and interrupt inputs
    input  wire logic          FIRST_COUNT_PIN,
    input  wire logic          SECOND_COUNT_PIN,
    input  wire logic          EXT_IRQ_A_INPUT,
    input  wire logic          EXT_IRQ_B_INPUT,
    input  wire logic          EXT_CLOCK,
    // Interrupt controller side
    input  wire logic          IRQ_A_POLARITY,
    input  wire logic          IRQ_B_POLARITY,
    input  wire logic          FIRST_IRQ_ENABLE,
    input  wire logic          SECOND_IRQ_ENABLE,
    input  wire logic          FIRST_VECTOR_ACK,
    input  wire logic          SECOND_VECTOR_ACK,
    output logic               FIRST_IRQ,
    output logic               SECOND_IRQ,
    // Consumers of timer 1 overflow
    output logic               SECOND_OVERFLOW_PULSE,
    // Auto-reload timers B and C: own clock tick in, chosen tick out
    input  wire logic [3:0]    AUX_OWN_TICK,
    output logic [3:0]         AUX_TICK
);

    logic [7:0] clk_sel_q;
    logic [7:0] mode_q;
    logic [7:0] tl0_q, th0_q, tl1_q, th1_q;
    logic       tf0_q, tf1_q, tr0_q, tr1_q;
    logic [7:0] rdata_q;

    // Write decode
    wire wr_cks  = SFR_REQ.wr && (SFR_REQ.addr == ADDR_CLOCK_SELECT);
    wire wr_rf   = SFR_REQ.wr && (SFR_REQ.addr == ADDR_RUN_FLAGS);
    wire wr_mode = SFR_REQ.wr && (SFR_REQ.addr == ADDR_MODE_CONFIG);
    wire wr_tl0  = SFR_REQ.wr && (SFR_REQ.addr == ADDR_FIRST_LOW);
    wire wr_th0  = SFR_REQ.wr && (SFR_REQ.addr == ADDR_FIRST_HIGH);
    wire wr_tl1  = SFR_REQ.wr && (SFR_REQ.addr == ADDR_SECOND_LOW);
    wire wr_th1  = SFR_REQ.wr && (SFR_REQ.addr == ADDR_SECOND_HIGH);

    // Configuration fields
    wire [1:0] m0   = mode_q[MC_FIRST_MODE +: 2];
    wire [1:0] m1   = mode_q[MC_SECOND_MODE +: 2];
    wire       ct0  = mode_q[MC_FIRST_CT];
    wire       ct1  = mode_q[MC_SECOND_CT];
    wire       gt0  = mode_q[MC_FIRST_GATE];
    wire       gt1  = mode_q[MC_SECOND_GATE];
    wire [1:0] pres = clk_sel_q[CKS_PRESCALE +: 2];
    wire       split = (m0 == MODE_SPLIT);

    // Pin synchronisers; stage one feeds only stage two
    logic [4:0] sync1_q, sync2_q, sync3_q;
    wire  [4:0] pins_in = {EXT_CLOCK, EXT_IRQ_B_INPUT, EXT_IRQ_A_INPUT,
                           SECOND_COUNT_PIN, FIRST_COUNT_PIN};
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            sync3_q <= 5'h00;
        end else begin
            sync1_q <= pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Falling edges on count pins, rising edges on external clock
    wire fall0   = sync3_q[0] && !sync2_q[0];
    wire fall1   = sync3_q[1] && !sync2_q[1];
    wire ext_ris = !sync3_q[4] && sync2_q[4];
    // Gate inputs active at configured polarity
    wire gate_a_on = (sync2_q[2] == IRQ_A_POLARITY);
    wire gate_b_on = (sync2_q[3] == IRQ_B_POLARITY);

    // Shared prescaler; counter restarts when the field changes
    logic [5:0] pre_cnt_q;
    logic [2:0] ext_cnt_q;
    logic [1:0] pres_last_q;
    wire  [5:0] pre_last = (pres == PRE_DIV4)  ? DIV4_LAST :
                           (pres == PRE_DIV48) ? DIV48_LAST : DIV12_LAST;
    wire pre_wrap  = (pre_cnt_q >= pre_last);
    wire ext_wrap  = ext_ris && (ext_cnt_q == EXT8_LAST);
    wire pre_tick  = (pres == PRE_EXT8) ? ext_wrap : pre_wrap;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_cnt_q   <= 6'h00;
            ext_cnt_q   <= 3'h0;
            pres_last_q <= 2'h0;
        end else begin
            pres_last_q <= pres;
            pre_cnt_q   <= (pre_wrap || pres != pres_last_q) ? 6'h00 : pre_cnt_q + 6'h01;
            if (ext_ris)
                ext_cnt_q <= ext_cnt_q + 3'h1;
        end
    end

    // Timer clocks: system clock is every edge, else prescaled tick
    wire tclk0 = clk_sel_q[CKS_FIRST]  ? 1'b1 : pre_tick;
    wire tclk1 = clk_sel_q[CKS_SECOND] ? 1'b1 : pre_tick;
    // Counter select overrides the clock select bit
    wire inc0  = ct0 ? fall0 : tclk0;
    // Timer 1 may not count pin edges while timer 0 is split
    wire inc1  = (ct1 && !split) ? fall1 : tclk1;

    // Run qualification
    wire run0  = tr0_q && (!gt0 || gate_a_on);
    // Split mode hands timer 1 run control to its mode field
    wire run1  = split ? (m1 != MODE_SPLIT)
                       : (tr1_q && (!gt1 || gate_b_on) && (m1 != MODE_SPLIT));
    wire step0 = run0 && inc0;
    wire step1 = run1 && inc1;
    // Split high byte: timer only, enabled by run bit of timer 1
    wire step_h = split && tr1_q && tclk0;

    // Next-count arithmetic shared by both timers
    logic [7:0] tl_n [2];
    logic [7:0] th_n [2];
    logic       ovf  [2];
    wire  [7:0] tl_c [2] = '{tl0_q, tl1_q};
    wire  [7:0] th_c [2] = '{th0_q, th1_q};
    wire  [1:0] md   [2] = '{m0, m1};
    wire        stp  [2] = '{step0, step1};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_tmr
            logic [12:0] c13;
            logic [15:0] c16;
            assign c13 = {th_c[g], tl_c[g][4:0]};
            assign c16 = {th_c[g], tl_c[g]};
            always_comb begin
                tl_n[g] = tl_c[g];
                th_n[g] = th_c[g];
                ovf[g]  = 1'b0;
                if (stp[g]) begin
                    case (md[g])
                        MODE_13BIT: begin
                            // Upper low-byte bits are left as they were
                            tl_n[g][4:0] = c13[4:0] + 5'h01;
                            th_n[g] = (c13[4:0] == 5'h1f) ? th_c[g] + 8'h01 : th_c[g];
                            ovf[g]  = (c13 == COUNT13_MAX);
                        end
                        MODE_16BIT: begin
                            {th_n[g], tl_n[g]} = c16 + 16'h0001;
                            ovf[g]  = (c16 == 16'hffff);
                        end
                        MODE_RELOAD: begin
                            // High byte only supplies the reload value
                            tl_n[g] = (tl_c[g] == 8'hff) ? th_c[g] : tl_c[g] + 8'h01;
                            ovf[g]  = (tl_c[g] == 8'hff);
                        end
                        default: begin
                            // Split: low byte 8-bit; timer 1 never steps here
                            tl_n[g] = tl_c[g] + 8'h01;
                            ovf[g]  = (tl_c[g] == 8'hff);
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Split high byte of timer 0 counts on its own
    wire       ovf_h   = step_h && (th0_q == 8'hff);
    wire [7:0] th0_nxt = split ? (step_h ? th0_q + 8'h01 : th0_q) : th_n[0];

    // Flag sources; split mode moves the timer 1 flag to the high byte
    wire set_tf0 = ovf[0];
    wire set_tf1 = split ? ovf_h : ovf[1];

    // Count registers: a register write takes priority over counting
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tl0_q <= RST_COUNT;
            th0_q <= RST_COUNT;
            tl1_q <= RST_COUNT;
            th1_q <= RST_COUNT;
        end else begin
            tl0_q <= wr_tl0 ? SFR_REQ.wdata : tl_n[0];
            th0_q <= wr_th0 ? SFR_REQ.wdata : th0_nxt;
            tl1_q <= wr_tl1 ? SFR_REQ.wdata : tl_n[1];
            th1_q <= wr_th1 ? SFR_REQ.wdata : th_n[1];
        end
    end

    // Control registers
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            clk_sel_q <= RST_CLOCK_SELECT;
            mode_q    <= RST_MODE_CONFIG;
            tr0_q     <= 1'b0;
            tr1_q     <= 1'b0;
        end else begin
            if (wr_cks)
                clk_sel_q <= SFR_REQ.wdata;
            if (wr_mode)
                mode_q <= SFR_REQ.wdata;
            if (wr_rf) begin
                tr0_q <= SFR_REQ.wdata[RF_FIRST_RUN];
                tr1_q <= SFR_REQ.wdata[RF_SECOND_RUN];
            end
        end
    end

    // Overflow flags: hardware set beats software or vector clear
    wire clr_tf0 = FIRST_VECTOR_ACK  || (wr_rf && !SFR_REQ.wdata[RF_FIRST_FLAG]);
    wire clr_tf1 = SECOND_VECTOR_ACK || (wr_rf && !SFR_REQ.wdata[RF_SECOND_FLAG]);
    wire wset0   = wr_rf && SFR_REQ.wdata[RF_FIRST_FLAG];
    wire wset1   = wr_rf && SFR_REQ.wdata[RF_SECOND_FLAG];
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            tf0_q <= 1'b0;
            tf1_q <= 1'b0;
        end else begin
            tf0_q <= set_tf0 || wset0 || (tf0_q && !clr_tf0);
            tf1_q <= set_tf1 || wset1 || (tf1_q && !clr_tf1);
        end
    end

    // Read mux; unmapped addresses read zero
    wire [7:0] rf_rd = {tf1_q, tr1_q, tf0_q, tr0_q, 4'h0};
    wire [7:0] rd_mux =
        (SFR_REQ.addr == ADDR_CLOCK_SELECT) ? clk_sel_q :
        (SFR_REQ.addr == ADDR_RUN_FLAGS)    ? rf_rd     :
        (SFR_REQ.addr == ADDR_MODE_CONFIG)  ? mode_q    :
        (SFR_REQ.addr == ADDR_FIRST_LOW)    ? tl0_q     :
        (SFR_REQ.addr == ADDR_FIRST_HIGH)   ? th0_q     :
        (SFR_REQ.addr == ADDR_SECOND_LOW)   ? tl1_q     :
        (SFR_REQ.addr == ADDR_SECOND_HIGH)  ? th1_q     : 8'h00;

    // Read data and timer 1 overflow pulse are registered
    logic t1_pulse_q;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q    <= 8'h00;
            t1_pulse_q <= 1'b0;
        end else begin
            if (SFR_REQ.rd)
                rdata_q <= rd_mux;
            // Still feeds baud and conversion consumers in split mode
            t1_pulse_q <= ovf[1];
        end
    end

    // Clock choices for auto-reload timers B and C
    generate
        for (g = 0; g < 4; g++) begin : g_aux
            assign AUX_TICK[g] = clk_sel_q[CKS_TMR_B_LOW + g] ? 1'b1 : AUX_OWN_TICK[g];
        end
    endgenerate

    assign SFR_RDATA             = rdata_q;
    assign SECOND_OVERFLOW_PULSE = t1_pulse_q;
    assign FIRST_IRQ             = tf0_q && FIRST_IRQ_ENABLE;
    assign SECOND_IRQ            = tf1_q && SECOND_IRQ_ENABLE;

endmodule
`default_nettype wire

// File: logic/dtcs_pkg.sv
// Package for the dual timer with clock select: map, fields, constants.
// Functional notes
// - Bit 7: timer C high byte system clock
// - Bit 6: timer C low byte system clock
// - Bit 5: timer B high byte system clock
// - Bit 4: timer B low byte system clock
// - Bit 3: timer 1 prescaled or system clock
// - Bit 2: timer 0 prescaled or system clock
// - Prescale 12, 4, 48, or external/8
// - Each count is two byte registers
// - Mode 0 thirteen bits, low five used
// - Mode 0 wrap sets overflow flag
// - Counter mode counts count pin falling edges
// - Count needs run and open gate
// - Run bit never clears the count
// - Timer 1 mirrors timer 0, gate B
// - Mode 1 uses all sixteen bits
// - Mode 2 reloads low from high
// - Split mode low byte uses timer 0 controls
// - Split high byte: timer, run1, flag1
// - Split: timer 1 no pins, no flag
// - Timer 1 mode 3 stops it
// - Mode codes 00, 01, 10, 11
// - Flags set by hardware, cleared by software
package dtcs_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_RUN_FLAGS    = 8'h88;
    localparam logic [7:0] ADDR_MODE_CONFIG  = 8'h89;
    localparam logic [7:0] ADDR_FIRST_LOW    = 8'h8a;
    localparam logic [7:0] ADDR_SECOND_LOW   = 8'h8b;
    localparam logic [7:0] ADDR_FIRST_HIGH   = 8'h8c;
    localparam logic [7:0] ADDR_SECOND_HIGH  = 8'h8d;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h8e;

    // Reset values
    localparam logic [7:0] RST_CLOCK_SELECT  = 8'h00;
    localparam logic [7:0] RST_MODE_CONFIG   = 8'h00;
    localparam logic [7:0] RST_COUNT         = 8'h00;

    // Clock select fields
    localparam int CKS_TMR_C_HIGH = 7;
    localparam int CKS_TMR_C_LOW  = 6;
    localparam int CKS_TMR_B_HIGH = 5;
    localparam int CKS_TMR_B_LOW  = 4;
    localparam int CKS_SECOND     = 3;
    localparam int CKS_FIRST      = 2;
    localparam int CKS_PRESCALE   = 0;

    // Run/flag fields
    localparam int RF_SECOND_FLAG = 7;
    localparam int RF_SECOND_RUN  = 6;
    localparam int RF_FIRST_FLAG  = 5;
    localparam int RF_FIRST_RUN   = 4;

    // Mode config fields
    localparam int MC_SECOND_GATE = 7;
    localparam int MC_SECOND_CT   = 6;
    localparam int MC_SECOND_MODE = 4;
    localparam int MC_FIRST_GATE  = 3;
    localparam int MC_FIRST_CT    = 2;
    localparam int MC_FIRST_MODE  = 0;

    // Mode codes
    localparam logic [1:0] MODE_13BIT  = 2'b00;
    localparam logic [1:0] MODE_16BIT  = 2'b01;
    localparam logic [1:0] MODE_RELOAD = 2'b10;
    localparam logic [1:0] MODE_SPLIT  = 2'b11;

    // Prescale codes and divisors
    localparam logic [1:0] PRE_DIV12 = 2'b00;
    localparam logic [1:0] PRE_DIV4  = 2'b01;
    localparam logic [1:0] PRE_DIV48 = 2'b10;
    localparam logic [1:0] PRE_EXT8  = 2'b11;
    localparam logic [5:0] DIV12_LAST = 6'd11;
    localparam logic [5:0] DIV4_LAST  = 6'd3;
    localparam logic [5:0] DIV48_LAST = 6'd47;
    localparam logic [2:0] EXT8_LAST  = 3'd7;

    // Mode 0 thirteen-bit wrap point
    localparam logic [12:0] COUNT13_MAX = 13'h1fff;

    // Register access request
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dtcs_sfr_req_t;

endpackage

// File: testbench/dtcs_assertions.sv
// Port-level assertions for the dual timer block.
`timescale 1ns/1ps
`default_nettype none
module dtcs_assertions
    import dtcs_pkg::*;
(
    // Clock and reset
    input wire logic          CLK,
    input wire logic          RSTN,
    // Register port
    input wire dtcs_sfr_req_t SFR_REQ,
    input wire logic [7:0]    SFR_RDATA,
    // Interrupt side
    input wire logic          FIRST_IRQ_ENABLE,
    input wire logic          SECOND_IRQ_ENABLE,
    input wire logic          FIRST_IRQ,
    input wire logic          SECOND_IRQ,
    // Auxiliary ticks
    input wire logic [3:0]    AUX_OWN_TICK,
    input wire logic [3:0]    AUX_TICK
);
    logic [7:0] cks_q;
    logic [7:0] mode_q;
    wire        map_hit = SFR_REQ.addr >= ADDR_RUN_FLAGS && SFR_REQ.addr <= ADDR_CLOCK_SELECT;

    // Shadow copies of written config, so reads and tick routing can be predicted
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cks_q  <= RST_CLOCK_SELECT;
            mode_q <= RST_MODE_CONFIG;
        end else if (SFR_REQ.wr) begin
            cks_q  <= (SFR_REQ.addr == ADDR_CLOCK_SELECT) ? SFR_REQ.wdata : cks_q;
            mode_q <= (SFR_REQ.addr == ADDR_MODE_CONFIG) ? SFR_REQ.wdata : mode_q;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // A pure read, no write in the same cycle
    sequence s_read(logic [7:0] a);
        SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == a;
    endsequence

    property p_aux; AUX_TICK == (AUX_OWN_TICK | cks_q[7:4]); endproperty
    a_aux: assert property (p_aux) else $error("aux tick routing wrong");
    property p_cks_read; s_read(ADDR_CLOCK_SELECT) |=> SFR_RDATA == cks_q; endproperty
    a_cks_read: assert property (p_cks_read) else $error("clock select read wrong");
    property p_mode_read; s_read(ADDR_MODE_CONFIG) |=> SFR_RDATA == mode_q; endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode read wrong");
    property p_unmapped; SFR_REQ.rd && !map_hit |=> SFR_RDATA == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold; !SFR_REQ.rd |=> $stable(SFR_RDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_irq1; FIRST_IRQ |-> FIRST_IRQ_ENABLE; endproperty
    a_irq1: assert property (p_irq1) else $error("first irq while disabled");
    property p_irq2; SECOND_IRQ |-> SECOND_IRQ_ENABLE; endproperty
    a_irq2: assert property (p_irq2) else $error("second irq while disabled");
    property p_rst; $rose(RSTN) |-> !FIRST_IRQ && !SECOND_IRQ; endproperty
    a_rst: assert property (p_rst) else $error("irq high out of reset");
endmodule
`default_nettype wire

// File: testbench/dtcs_pin_model.sv
// Count pin model: makes a burst of falling edges on demand.
`timescale 1ns/1ps
`default_nettype none
module dtcs_pin_model (
    // Clock and command
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] n,
    // Pin, idles high
    output logic            pin
);
    logic [2:0] ph_q = 3'h0;
    logic [3:0] left_q = 4'h0;
    logic       go_s;
    initial pin = 1'b1;
    // Each level held three cycles so a two-flop sampler never misses one
    always @(posedge clk) begin
        go_s = go;
        #1;
        if (left_q == 4'h0) begin
            left_q <= go_s ? n : 4'h0;
        end else begin
            pin  <= (ph_q < 3'h3) ? 1'b0 : 1'b1;
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            left_q <= (ph_q == 3'h5) ? left_q - 4'h1 : left_q;
        end
    end
endmodule
`default_nettype wire

// File: testbench/test_dtcs_top.sv
// Self-checking bench for the dual timer block.
`timescale 1ns/1ps
`default_nettype none
module test_dtcs_top;
    import dtcs_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dtcs_row_t;
    logic          clk = 1'b0;
    logic          rstn = 1'b0;
    dtcs_sfr_req_t req = '0;
    logic [7:0]    rdata;
    logic [7:0]    v;
    logic          pin;
    logic          gate_a = 1'b0;
    logic          ack1 = 1'b0;
    logic          go = 1'b0;
    logic [5:0]    ph_q = 6'h00;
    logic          irq1;
    logic          irq2;
    logic [3:0]    aux;
    logic          t1p;
    int            pulses = 0;
    int            err_count = 0;
    int            checked = 0;
    int            divs [4] = '{12, 4, 48, 32};
    dtcs_row_t     rows [9] = '{
        '{8'h8e, 8'ha5, 8'ha5},
        '{8'h89, 8'h5a, 8'h5a},
        '{8'h8a, 8'h12, 8'h12},
        '{8'h8c, 8'h34, 8'h34},
        '{8'h8b, 8'h56, 8'h56},
        '{8'h8d, 8'h78, 8'h78},
        '{8'h88, 8'ha0, 8'ha0},
        '{8'h88, 8'h0f, 8'h00},
        '{8'h90, 8'h33, 8'h00}};

    // Clock, and a free pattern for the external clock and aux ticks
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        #1 ph_q <= ph_q + 6'h01;
    end

    dtcs_top dut_u (
        .CLK(clk), .RSTN(rstn), .SFR_REQ(req), .SFR_RDATA(rdata),
        .FIRST_COUNT_PIN(pin), .SECOND_COUNT_PIN(1'b1), .EXT_IRQ_A_INPUT(gate_a),
        .EXT_IRQ_B_INPUT(1'b1), .EXT_CLOCK(ph_q[1]), .IRQ_A_POLARITY(ph_q[0] | 1'b1),
        .IRQ_B_POLARITY(1'b1), .FIRST_IRQ_ENABLE(rstn), .SECOND_IRQ_ENABLE(rstn),
        .FIRST_VECTOR_ACK(ack1), .SECOND_VECTOR_ACK(1'b0), .FIRST_IRQ(irq1),
        .SECOND_IRQ(irq2), .SECOND_OVERFLOW_PULSE(t1p), .AUX_OWN_TICK(ph_q[5:2]),
        .AUX_TICK(aux));
    dtcs_pin_model pin_u (.clk(clk), .go(go), .n(4'h5), .pin(pin));

    // Overflow pulses of timer 1, counted away from the launching edge
    always @(negedge clk) begin
        if (t1p === 1'b1) pulses++;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h, want %h", $time, s, e);
        end
    endtask
    task automatic rng(input logic [7:0] s, input logic [7:0] lo, input logic [7:0] hi);
        chk({7'h0, s >= lo && s <= hi}, 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{a, 1'b1, 1'b0, d};
        @(posedge clk);
        #1 req = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 req = '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        #1 req = '0;
        d = rdata;
    endtask
    // Bounded wait, the irq is looked at once the edge has settled
    task automatic wait_irq(input bit b);
        for (int i = 0; i < 40 && (b ? irq2 : irq1) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk({7'h0, b ? irq2 : irq1}, 8'h01);
    endtask
    task report_and_stop;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog well beyond the expected run of some 2300 cycles
    initial begin
        #100000;
        err_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk);
        #1 rstn = 1'b1;
        for (int a = 8'h88; a <= 8'h8e; a++) begin
            rd(a[7:0], v);
            chk(v, 8'h00);
        end
        $display("reset test done");
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, v);
            chk(v, rows[k].e);
        end
        $display("register table test done");
        // Sixteen-bit wrap on the system clock, then flag cleared by ack
        wr(8'h8e, 8'h04); wr(8'h89, 8'h01); wr(8'h8a, 8'hfe); wr(8'h8c, 8'hff);
        wr(8'h88, 8'h10);
        wait_irq(0);
        wr(8'h88, 8'h20);
        rd(8'h88, v);
        chk(v, 8'h20);
        rd(8'h8c, v);
        chk(v, 8'h00);
        @(posedge clk);
        #1 ack1 = 1'b1;
        @(posedge clk);
        #1 ack1 = 1'b0;
        chk({7'h0, irq1}, 8'h00);
        // Stopped count holds, restarting does not clear it
        wr(8'h8a, 8'h80);
        repeat (10) @(posedge clk);
        rd(8'h8a, v);
        chk(v, 8'h80);
        wr(8'h88, 8'h10); wr(8'h88, 8'h00);
        rd(8'h8a, v);
        rng(v, 8'h81, 8'h83);
        $display("overflow and hold test done");
        // Thirteen-bit wrap: high byte must reach zero with the low five bits
        wr(8'h89, 8'h00); wr(8'h8c, 8'hff); wr(8'h8a, 8'hff); wr(8'h88, 8'h10);
        wait_irq(0);
        wr(8'h88, 8'h00);
        rd(8'h8c, v);
        chk(v, 8'h00);
        rd(8'h8a, v);
        rng({3'h0, v[4:0]}, 8'h00, 8'h07);
        // Auto-reload keeps the high byte
        wr(8'h89, 8'h02); wr(8'h8c, 8'hf0); wr(8'h8a, 8'hfe); wr(8'h88, 8'h10);
        wait_irq(0);
        wr(8'h88, 8'h00);
        rd(8'h8c, v);
        chk(v, 8'hf0);
        rd(8'h8a, v);
        rng(v, 8'hf0, 8'hf7);
        $display("mode 0 and mode 2 test done");
        // Every prescale code over 480 cycles; the external clock rises every 4
        for (int k = 0; k < 4; k++) begin
            wr(8'h89, 8'h01); wr(8'h8a, 8'h00); wr(8'h8c, 8'h00);
            wr(8'h8e, k[7:0]); wr(8'h88, 8'h10);
            repeat (480) @(posedge clk);
            wr(8'h88, 8'h00);
            rd(8'h8a, v);
            rng(v, 8'(480 / divs[k] - 1), 8'(480 / divs[k] + 3));
        end
        $display("prescale test done");
        // Counter mode counts pin falls; the system clock select is ignored
        wr(8'h8e, 8'h04); wr(8'h89, 8'h05); wr(8'h8a, 8'h00); wr(8'h88, 8'h10);
        @(posedge clk);
        #1 go = 1'b1;
        @(posedge clk);
        #1 go = 1'b0;
        repeat (45) @(posedge clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, v);
        chk(v, 8'h05);
        // Gate closed holds the count, open lets it run
        wr(8'h89, 8'h09); wr(8'h8a, 8'h00); wr(8'h88, 8'h10);
        repeat (20) @(posedge clk);
        rd(8'h8a, v);
        chk(v, 8'h00);
        gate_a = 1'b1;
        repeat (20) @(posedge clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, v);
        rng(v, 8'h10, 8'h20);
        $display("counter and gate test done");
        // Split mode: high byte runs on the second run bit, sets the second flag
        wr(8'h89, 8'h03); wr(8'h8a, 8'h00); wr(8'h8c, 8'hfe); wr(8'h88, 8'h40);
        wait_irq(1);
        wr(8'h88, 8'h00);
        rd(8'h8a, v);
        chk(v, 8'h00);
        $display("split mode test done");
        // Timer 1 sixteen-bit wrap on the system clock: flag and one consumer pulse
        wr(8'h89, 8'h10); wr(8'h8b, 8'hfe); wr(8'h8d, 8'hff); wr(8'h8e, 8'h0c);
        wr(8'h88, 8'h40);
        wait_irq(1);
        wr(8'h88, 8'h00);
        chk(pulses[7:0], 8'h01);
        $display("second timer overflow test done");
        report_and_stop();
    end
endmodule

bind dtcs_top dtcs_assertions chk_u (
    .CLK(CLK), .RSTN(RSTN), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
    .FIRST_IRQ_ENABLE(FIRST_IRQ_ENABLE), .SECOND_IRQ_ENABLE(SECOND_IRQ_ENABLE),
    .FIRST_IRQ(FIRST_IRQ), .SECOND_IRQ(SECOND_IRQ), .AUX_OWN_TICK(AUX_OWN_TICK),
    .AUX_TICK(AUX_TICK));
`default_nettype wire
